// *** rtl/modbus_frame_pkg.sv ***
package modbus_frame_pkg;

    localparam longint CLK_HZ        = 50_000_000;
    localparam longint US_PER_S      = 1_000_000;
    localparam int     MS_CYCLES     = int'(CLK_HZ / 1000);

    // Silent gap per rate, in microseconds, rounded up to cycles
    localparam longint GAP_9600_US   = 4000;
    localparam longint GAP_19200_US  = 2000;
    localparam longint GAP_FAST_US   = 1750;
    localparam longint GAP_9600_CYC  = (GAP_9600_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
    localparam longint GAP_19200_CYC = (GAP_19200_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
    localparam longint GAP_FAST_CYC  = (GAP_FAST_US * CLK_HZ + US_PER_S - 1) / US_PER_S;

    localparam logic [2:0] BAUD_9600  = 3'h0;
    localparam logic [2:0] BAUD_19200 = 3'h1;

    localparam logic [13:0] TIMEOUT_MS_MAX  = 14'h2710;
    localparam logic [13:0] TIMEOUT_MS_INIT = 14'h0000;
    localparam logic [6:0]  WAIT_MS_MAX     = 7'h64;
    localparam logic [6:0]  WAIT_MS_INIT    = 7'h0a;

    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [7:0] FC_READ    = 8'h03;
    localparam logic [7:0] FC_WRITE1  = 8'h06;
    localparam logic [7:0] FC_DIAG    = 8'h08;
    localparam logic [7:0] FC_WRITEN  = 8'h10;

    localparam logic [8:0] LEN_FIXED    = 9'h008;
    localparam logic [8:0] LEN_WN_MIN   = 9'h00b;
    localparam logic [8:0] LEN_WN_MAX   = 9'h029;
    localparam logic [8:0] LEN_MIN      = 9'h004;
    localparam logic [8:0] LEN_LIMIT    = 9'h100;
    localparam int         QUERY_MAX_LEN = 41;

    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] func;
        logic [8:0] len;
        logic       bcast;
        logic       bad_func;
    } query_info_s;

    typedef enum logic [4:0] {
        TX_IDLE   = 5'b00001,
        TX_HOLD   = 5'b00010,
        TX_SEND   = 5'b00100,
        TX_CRC_LO = 5'b01000,
        TX_CRC_HI = 5'b10000
    } tx_state_e;

endpackage

// *** rtl/crc16_byte_step.sv ***
`timescale 1ns/1ns
module crc16_byte_step (
    input  wire logic [15:0] crc_i,  // Running remainder
    input  wire logic [7:0]  data_i, // Byte to fold in
    output logic      [15:0] crc_o   // Remainder after the byte
);
    always_comb begin
        logic [15:0] c;
        c = crc_i ^ {8'h00, data_i};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ modbus_frame_pkg::CRC_POLY) : (c >> 1);
        end
        crc_o = c;
    end
endmodule

// *** rtl/modbus_rtu_slave_framer.sv ***
`timescale 1ns/1ns
module modbus_rtu_slave_framer #(
    parameter int MAX_BYTES     = modbus_frame_pkg::QUERY_MAX_LEN,
    parameter int IDX_W         = $clog2(MAX_BYTES),
    parameter int GAP_9600_CYC  = int'(modbus_frame_pkg::GAP_9600_CYC),
    parameter int GAP_19200_CYC = int'(modbus_frame_pkg::GAP_19200_CYC),
    parameter int GAP_FAST_CYC  = int'(modbus_frame_pkg::GAP_FAST_CYC),
    parameter int MS_CYC        = modbus_frame_pkg::MS_CYCLES
) (
    input  wire logic              sys_clk_i,        // System clock
    input  wire logic              rst_b_i,          // Sync reset, low
    input  wire logic [2:0]        baud_sel_i,       // Rate switch pins
    input  wire logic [4:0]        addr_sel_i,       // Address switch pins
    input  wire logic              cfg_wr_i,         // Load settings
    input  wire logic [13:0]       cfg_timeout_ms_i, // Timeout, ms
    input  wire logic [6:0]        cfg_wait_ms_i,    // Wait time, ms
    input  wire logic              rx_valid_i,       // Byte received
    input  wire logic [7:0]        rx_data_i,        // Received byte
    input  wire logic              rx_err_i,         // Framing or parity
    output logic                   query_valid_o,    // Query accepted
    output modbus_frame_pkg::query_info_s query_info_o, // Query summary
    input  wire logic [IDX_W-1:0]  rd_idx_i,         // Query byte index
    output logic      [7:0]        rd_data_o,        // Query byte
    input  wire logic              resp_valid_i,     // Response byte
    input  wire logic [7:0]        resp_data_i,      // Response data
    input  wire logic              resp_last_i,      // Last data byte
    output logic                   resp_ready_o,     // Response taken
    output logic                   tx_valid_o,       // Byte to send
    output logic      [7:0]        tx_data_o,        // Byte to send
    input  wire logic              tx_ready_i,       // Sender takes byte
    input  wire logic              alarm_clear_i,    // Clear timeout
    output logic                   comm_timeout_o    // Timeout alarm
);
    // ----------------------------------------------------------------
    // Pin synchronisers and settings
    // ----------------------------------------------------------------
    logic [2:0]  baud_m_q, baud_s_q;
    logic [4:0]  addr_m_q, addr_s_q;
    logic [13:0] timeout_q;
    logic [6:0]  wait_q;
    logic [17:0] gap_lim;
    logic [7:0]  own_addr;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            baud_m_q <= 3'h0;
            baud_s_q <= 3'h0;
            addr_m_q <= 5'h00;
            addr_s_q <= 5'h00;
        end else begin
            baud_m_q <= baud_sel_i;
            baud_s_q <= baud_m_q;
            addr_m_q <= addr_sel_i;
            addr_s_q <= addr_m_q;
        end
    end

    // Out-of-range settings clamp to the top of their range
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            timeout_q <= modbus_frame_pkg::TIMEOUT_MS_INIT;
            wait_q    <= modbus_frame_pkg::WAIT_MS_INIT;
        end else if (cfg_wr_i) begin
            timeout_q <= (cfg_timeout_ms_i > modbus_frame_pkg::TIMEOUT_MS_MAX) ?
                         modbus_frame_pkg::TIMEOUT_MS_MAX : cfg_timeout_ms_i;
            wait_q    <= (cfg_wait_ms_i > modbus_frame_pkg::WAIT_MS_MAX) ?
                         modbus_frame_pkg::WAIT_MS_MAX : cfg_wait_ms_i;
        end
    end

    always_comb begin
        unique case (baud_s_q)
            modbus_frame_pkg::BAUD_9600:  gap_lim = 18'(GAP_9600_CYC);
            modbus_frame_pkg::BAUD_19200: gap_lim = 18'(GAP_19200_CYC);
            default:                      gap_lim = 18'(GAP_FAST_CYC);
        endcase
    end

    assign own_addr = {3'h0, addr_s_q};

    // ----------------------------------------------------------------
    // Receive framing and check
    // ----------------------------------------------------------------
    logic [7:0]  rx_buf_q [MAX_BYTES];
    logic [8:0]  rx_cnt_q;
    logic [15:0] rx_crc_q, rx_crc_nx;
    logic [17:0] gap_q;
    logic        rx_err_q;
    logic        frame_end, frame_ok, addr_hit, is_bc, supported, len_ok;
    logic [7:0]  f_addr, f_func;
    logic        query_valid_q;
    modbus_frame_pkg::query_info_s info_q;

    crc16_byte_step rx_crc_step (
        .crc_i  (rx_cnt_q == 9'h000 ? modbus_frame_pkg::CRC_INIT : rx_crc_q),
        .data_i (rx_data_i),
        .crc_o  (rx_crc_nx)
    );

    // A frame ends once the line has been quiet for the silent gap
    assign frame_end = (rx_cnt_q != 9'h000) && !rx_valid_i &&
                       (gap_q == gap_lim - 18'h1);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rx_cnt_q <= 9'h000;
            rx_crc_q <= modbus_frame_pkg::CRC_INIT;
            rx_err_q <= 1'b0;
            gap_q    <= 18'h0;
        end else if (rx_valid_i) begin
            gap_q    <= 18'h0;
            rx_crc_q <= rx_crc_nx;
            rx_err_q <= (rx_cnt_q == 9'h000) ? rx_err_i : (rx_err_q | rx_err_i);
            if (rx_cnt_q <= modbus_frame_pkg::LEN_LIMIT) begin
                rx_cnt_q <= rx_cnt_q + 9'h001;
            end
        end else if (frame_end) begin
            rx_cnt_q <= 9'h000;
            gap_q    <= 18'h0;
        end else if (rx_cnt_q != 9'h000) begin
            gap_q <= gap_q + 18'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rx_valid_i && rx_cnt_q < 9'(MAX_BYTES)) begin
            rx_buf_q[rx_cnt_q[IDX_W-1:0]] <= rx_data_i;
        end
    end

    assign f_addr = rx_buf_q[0];
    assign f_func = rx_buf_q[1];

    always_comb begin
        addr_hit  = (own_addr != modbus_frame_pkg::ADDR_BCAST) && (f_addr == own_addr);
        is_bc     = (f_addr == modbus_frame_pkg::ADDR_BCAST);
        supported = 1'b1;
        len_ok    = 1'b0;
        unique case (f_func)
            modbus_frame_pkg::FC_READ,
            modbus_frame_pkg::FC_WRITE1,
            modbus_frame_pkg::FC_DIAG:
                len_ok = (rx_cnt_q == modbus_frame_pkg::LEN_FIXED);
            modbus_frame_pkg::FC_WRITEN:
                len_ok = (rx_cnt_q >= modbus_frame_pkg::LEN_WN_MIN) &&
                         (rx_cnt_q <= modbus_frame_pkg::LEN_WN_MAX);
            default:
                supported = 1'b0;
        endcase
        // A zero remainder over data plus low-first check field means a match
        frame_ok = !rx_err_q && (rx_crc_q == 16'h0000) &&
                   (rx_cnt_q >= modbus_frame_pkg::LEN_MIN) &&
                   (rx_cnt_q <= modbus_frame_pkg::LEN_LIMIT) &&
                   (!supported || len_ok) &&
                   (addr_hit || (is_bc &&
                    (f_func == modbus_frame_pkg::FC_WRITE1 ||
                     f_func == modbus_frame_pkg::FC_WRITEN)));
    end

    // Unsupported codes are passed on flagged so an exception can be built
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            query_valid_q <= 1'b0;
            info_q        <= '0;
        end else begin
            query_valid_q <= frame_end && frame_ok;
            if (frame_end && frame_ok) begin
                info_q.addr     <= f_addr;
                info_q.func     <= f_func;
                info_q.len      <= rx_cnt_q;
                info_q.bcast    <= is_bc;
                info_q.bad_func <= !supported;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rd_data_o <= 8'h00;
        end else begin
            rd_data_o <= rx_buf_q[rd_idx_i];
        end
    end

    assign query_valid_o = query_valid_q;
    assign query_info_o  = info_q;

    // ----------------------------------------------------------------
    // Communication timeout monitor
    // ----------------------------------------------------------------
    logic [15:0] ms_cnt_q;
    logic        ms_tick;
    logic [13:0] idle_ms_q;
    logic        alarm_q;

    assign ms_tick = (ms_cnt_q == 16'(MS_CYC - 1));

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || ms_tick) begin
            ms_cnt_q <= 16'h0000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || query_valid_q) begin
            idle_ms_q <= 14'h0000;
        end else if (ms_tick && idle_ms_q != 14'h3fff) begin
            idle_ms_q <= idle_ms_q + 14'h0001;
        end
    end

    // Raising the alarm wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            alarm_q <= 1'b0;
        end else if (timeout_q != 14'h0000 && idle_ms_q >= timeout_q) begin
            alarm_q <= 1'b1;
        end else if (alarm_clear_i) begin
            alarm_q <= 1'b0;
        end
    end

    assign comm_timeout_o = alarm_q;

    // ----------------------------------------------------------------
    // Response hold-off and transmit
    // ----------------------------------------------------------------
    modbus_frame_pkg::tx_state_e tx_state_q;
    logic [23:0] hold_cnt_q, hold_lim;
    logic [15:0] tx_crc_q, tx_crc_nx;
    logic        resp_bcast_q, tx_valid_q, can_load, resp_take;
    logic [7:0]  tx_data_q, crc_lo;

    crc16_byte_step tx_crc_step (
        .crc_i  (tx_crc_q),
        .data_i (resp_data_i),
        .crc_o  (tx_crc_nx)
    );

    assign hold_lim     = 24'(wait_q) * 24'(MS_CYC);
    assign can_load     = !tx_valid_q || tx_ready_i;
    assign resp_ready_o = (tx_state_q == modbus_frame_pkg::TX_SEND) && can_load;
    assign resp_take    = resp_ready_o && resp_valid_i;
    assign crc_lo       = tx_crc_q[7:0];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tx_state_q   <= modbus_frame_pkg::TX_IDLE;
            hold_cnt_q   <= 24'h0;
            resp_bcast_q <= 1'b0;
            tx_crc_q     <= modbus_frame_pkg::CRC_INIT;
        end else begin
            unique case (tx_state_q)
                modbus_frame_pkg::TX_IDLE: begin
                    tx_crc_q   <= modbus_frame_pkg::CRC_INIT;
                    hold_cnt_q <= 24'h0;
                    if (query_valid_q) begin
                        resp_bcast_q <= info_q.bcast;
                        tx_state_q   <= info_q.bcast ? modbus_frame_pkg::TX_SEND
                                                     : modbus_frame_pkg::TX_HOLD;
                    end
                end
                modbus_frame_pkg::TX_HOLD: begin
                    // Silent gap already spent before the query was flagged
                    if (hold_cnt_q >= hold_lim) begin
                        tx_state_q <= modbus_frame_pkg::TX_SEND;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 24'h1;
                    end
                end
                modbus_frame_pkg::TX_SEND: begin
                    if (resp_take) begin
                        tx_crc_q <= tx_crc_nx;
                        if (resp_last_i) begin
                            tx_state_q <= resp_bcast_q ? modbus_frame_pkg::TX_IDLE
                                                       : modbus_frame_pkg::TX_CRC_LO;
                        end
                    end
                end
                modbus_frame_pkg::TX_CRC_LO: begin
                    if (can_load) begin
                        tx_state_q <= modbus_frame_pkg::TX_CRC_HI;
                    end
                end
                modbus_frame_pkg::TX_CRC_HI: begin
                    if (can_load) begin
                        tx_state_q <= modbus_frame_pkg::TX_IDLE;
                    end
                end
                default: tx_state_q <= modbus_frame_pkg::TX_IDLE;
            endcase
        end
    end

    // Broadcast replies are consumed and dropped, never put on the line
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
        end else if (resp_take && !resp_bcast_q) begin
            tx_valid_q <= 1'b1;
            tx_data_q  <= resp_data_i;
        end else if (tx_state_q == modbus_frame_pkg::TX_CRC_LO && can_load) begin
            tx_valid_q <= 1'b1;
            tx_data_q  <= crc_lo;
        end else if (tx_state_q == modbus_frame_pkg::TX_CRC_HI && can_load) begin
            tx_valid_q <= 1'b1;
            tx_data_q  <= tx_crc_q[15:8];
        end else if (tx_ready_i) begin
            tx_valid_q <= 1'b0;
        end
    end

    assign tx_valid_o = tx_valid_q;
    assign tx_data_o  = tx_data_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    timeout_raise_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(alarm_q) |-> ($past(timeout_q) != 14'h0) && ($past(idle_ms_q) >= $past(timeout_q)))
        else $error("timeout alarm raised early");

    timeout_off_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (timeout_q == 14'h0 && !alarm_q && !cfg_wr_i) |=> !alarm_q)
        else $error("alarm raised with monitoring off");

    hold_len_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (tx_state_q == modbus_frame_pkg::TX_HOLD) ##1 (tx_state_q == modbus_frame_pkg::TX_SEND)
        |-> $past(hold_cnt_q) >= hold_lim)
        else $error("response released before wait time");

    hold_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (tx_state_q == modbus_frame_pkg::TX_HOLD) |-> !resp_ready_o && !$rose(tx_valid_q))
        else $error("response taken during hold-off");

    gap_end_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        query_valid_o |-> $past(gap_q) == $past(gap_lim) - 18'h1)
        else $error("frame closed before silent gap");

    addr_match_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        query_valid_o |-> (query_info_o.addr == $past(own_addr)) || query_info_o.bcast)
        else $error("query for another slave accepted");

    bcast_code_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (query_valid_o && query_info_o.bcast) |->
        (query_info_o.func == modbus_frame_pkg::FC_WRITE1 ||
         query_info_o.func == modbus_frame_pkg::FC_WRITEN))
        else $error("broadcast with forbidden code accepted");

    read_len_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (query_valid_o && query_info_o.func == modbus_frame_pkg::FC_READ)
        |-> query_info_o.len == modbus_frame_pkg::LEN_FIXED)
        else $error("read query of wrong length accepted");

    crc_ok_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        query_valid_o |-> $past(rx_crc_q) == 16'h0000)
        else $error("query accepted with bad check field");

    bcast_silent_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (resp_bcast_q && tx_state_q != modbus_frame_pkg::TX_IDLE && !tx_valid_q) |=> !tx_valid_q)
        else $error("byte sent for a broadcast");

    crc_low_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (tx_state_q == modbus_frame_pkg::TX_CRC_LO && can_load)
        |=> tx_valid_q && tx_data_q == $past(crc_lo) && tx_state_q == modbus_frame_pkg::TX_CRC_HI)
        else $error("check field low byte not sent first");

endmodule

// *** testbench/rtu_master_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Bus master stand-in
// ----------------------------------------
module rtu_master_model (
    input  wire logic       sys_clk_i,  // Clock
    input  wire logic       slow_i,     // Stall taking of slave bytes
    output logic            rx_valid_o, // Byte to slave
    output logic [7:0]      rx_data_o,  // Byte to slave
    input  wire logic       tx_valid_i, // Byte from slave
    input  wire logic [7:0] tx_data_i,  // Byte from slave
    output logic            tx_ready_o  // Slave byte taken
);
    logic [7:0] got_q[$];
    logic [7:0] cnt_q = 8'h00;

    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
    end

    always @(posedge sys_clk_i) begin
        cnt_q <= cnt_q + 8'h01;
        if (tx_valid_i && tx_ready_o) begin
            got_q.push_back(tx_data_i);
        end
    end

    // Slow mode takes a byte only every other pair of cycles
    assign tx_ready_o = !slow_i || cnt_q[1];

    function automatic logic [15:0] crc(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction

    // Idle data is inverted so a stale byte never looks valid
    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [15:0] c;
        c = crc(b) ^ {15'h0000, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            @(posedge sys_clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o  <= b[i];
            @(posedge sys_clk_i);
            rx_valid_o <= 1'b0;
            rx_data_o  <= ~b[i];
        end
    endtask
endmodule

// *** testbench/modbus_rtu_slave_framer_tb_top.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Framer bench
// ----------------------------------------
module modbus_rtu_slave_framer_tb_top;
    logic        sys_clk_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic        cfg_wr_i  = 1'b0;
    logic [13:0] cfg_t     = 14'h0000;
    logic        resp_v    = 1'b0;
    logic [7:0]  resp_d    = 8'h00;
    logic        resp_l    = 1'b0;
    logic        clr       = 1'b0;
    logic        slow      = 1'b0;
    logic        rx_e      = 1'b0;
    logic [6:0]  cfg_w     = 7'h00;
    logic        rx_v, tx_v, tx_r, q_v, resp_r, alarm;
    logic [7:0]  rx_d, tx_d, rd_d;
    modbus_frame_pkg::query_info_s info;
    int          errors      = 0;
    int          check_count = 0;
    int          cycles      = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    rtu_master_model master (.sys_clk_i(sys_clk_i), .slow_i(slow), .rx_valid_o(rx_v),
        .rx_data_o(rx_d), .tx_valid_i(tx_v), .tx_data_i(tx_d), .tx_ready_o(tx_r));

    // Short gaps and a 50-cycle millisecond keep the run small
    modbus_rtu_slave_framer #(.GAP_9600_CYC(40), .GAP_19200_CYC(20), .GAP_FAST_CYC(18),
        .MS_CYC(50)) dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .baud_sel_i(3'h0),
        .addr_sel_i(5'h01), .cfg_wr_i(cfg_wr_i), .cfg_timeout_ms_i(cfg_t),
        .cfg_wait_ms_i(cfg_w), .rx_valid_i(rx_v), .rx_data_i(rx_d), .rx_err_i(rx_e),
        .query_valid_o(q_v), .query_info_o(info), .rd_idx_i(6'h00), .rd_data_o(rd_d),
        .resp_valid_i(resp_v), .resp_data_i(resp_d), .resp_last_i(resp_l),
        .resp_ready_o(resp_r), .tx_valid_o(tx_v), .tx_data_o(tx_d), .tx_ready_i(tx_r),
        .alarm_clear_i(clr), .comm_timeout_o(alarm));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Sixty idle cycles also give the master its inter-frame gap
    task automatic wait_query(output logic s, output int a);
        s = 1'b0;
        a = 0;
        repeat (60) begin
            @(posedge sys_clk_i);
            if (s) a++;
            if (q_v === 1'b1) s = 1'b1;
        end
    endtask

    task automatic resp(input logic [7:0] b[$], output int n);
        n = 0;
        foreach (b[i]) begin
            resp_v <= 1'b1;
            resp_d <= b[i];
            resp_l <= (i == b.size() - 1);
            do begin
                @(posedge sys_clk_i);
                n++;
            end while (resp_r !== 1'b1 && n < 2000);
        end
        resp_v <= 1'b0;
        resp_l <= 1'b0;
    endtask

    task automatic cfg(input logic [13:0] t, input logic c);
        @(posedge sys_clk_i);
        cfg_t    <= t;
        cfg_wr_i <= !c;
        clr      <= c;
        @(posedge sys_clk_i);
        cfg_wr_i <= 1'b0;
        clr      <= 1'b0;
    endtask

    task automatic t_read();
        logic s;
        int a, n;
        logic [7:0] e[$];
        logic [15:0] c;
        e = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h64};
        master.send('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0);
        wait_query(s, a);
        check("accept", s, 1);
        check("info", info, {8'h01, 8'h03, 9'h008, 2'b00});
        check("byte0", rd_d, 8'h01);
        slow <= 1'b1;
        resp(e, n);
        check("hold", (n + a) >= 500, 1);
        for (int i = 0; i < 300 && master.got_q.size() < 7; i++) @(posedge sys_clk_i);
        c = master.crc(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        check("tx count", master.got_q.size(), 7);
        foreach (e[i]) check("tx byte", master.got_q[i], e[i]);
        check("no alarm", alarm, 0);
        $display("test read done");
    endtask

    task automatic t_reject();
        logic s;
        int a, n;
        logic [7:0] f[4][2] = '{'{8'h01, 8'h03}, '{8'h02, 8'h03}, '{8'h00, 8'h03},
                                '{8'h00, 8'h08}};
        for (int i = 0; i < 4; i++) begin
            master.send('{f[i][0], f[i][1], 8'h00, 8'h00, 8'h00, 8'h01}, i == 0);
            wait_query(s, a);
            check("refuse", s, 0);
        end
        // A line error on any byte must spoil an otherwise good frame
        rx_e <= 1'b1;
        master.send('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
        rx_e <= 1'b0;
        wait_query(s, a);
        check("line error", s, 0);
        master.send('{8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h05}, 1'b0);
        wait_query(s, a);
        check("bcast", s, 1);
        check("bcast info", info, {8'h00, 8'h06, 9'h008, 2'b10});
        resp('{8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h05}, n);
        repeat (300) @(posedge sys_clk_i);
        check("bcast silent", master.got_q.size(), 7);
        $display("test reject done");
    endtask

    task automatic t_timeout();
        logic s;
        int a;
        cfg(14'h0002, 1'b0);
        master.send('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
        wait_query(s, a);
        check("unsupported", {s, info[0]}, 2'b11);
        cfg(14'h0002, 1'b1);
        // Two ticks can land as soon as 52 cycles after the query pulse
        repeat (20) @(posedge sys_clk_i);
        check("early", alarm, 0);
        repeat (80) @(posedge sys_clk_i);
        check("alarm", alarm, 1);
        cfg(14'h0000, 1'b0);
        cfg(14'h0000, 1'b1);
        repeat (150) @(posedge sys_clk_i);
        check("disabled", alarm, 0);
        $display("test timeout done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hang is cut off well beyond the two thousand or so cycles the tests need
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        t_read();
        t_reject();
        t_timeout();
        finish_test();
    end
endmodule
